// >>> core/dcsf_pkg.sv
// How it works
// - Reset leaves units in programming mode, idle
// - Two words out, two in, every period
// - Powered-down ADC sends zero, DAC ignores
// - Host sends second unit's word first
// - Mode and rate settings commit together
// - Mode register write selects data/mixed mode
// - Cascade length resets to 000b, program 001b
// - Loop-back host sends one word per sync seen while not busy
// - No loop-back: back-to-back words accepted
// - Mixed mode: extra words taken as control
// - Host sends control words before DAC word
// - Loop-back control word keeps old DAC
// - Loop-back: output sync shifts host word into device
// - Syncs high, one clock before MSB
// - Sixteen-bit words, sync with each word
// - Nonzero address: decrement and forward word
// - Count forwarded data words, load DAC at cascade length
package dcsf_pkg;
   // ************************************************************
   // Link word layout
   // ************************************************************
   localparam int         WORD_W     = 16;
   localparam logic [4:0] WORD_BITS  = 5'h10;
   localparam int         CTL_BIT    = 15;
   localparam int         RD_BIT     = 14;
   localparam int         ADDR_LO    = 11;
   localparam int         REG_LO     = 8;
   localparam logic [2:0] REG_MODE   = 3'h0;
   localparam logic [2:0] REG_RATE   = 3'h1;
   localparam logic [2:0] REG_POWER  = 3'h2;
   // ************************************************************
   // Unit register fields and reset values
   // ************************************************************
   localparam int         DATA_BIT   = 0;
   localparam int         MIXED_BIT  = 1;
   localparam int         CASC_LO    = 2;
   localparam int         ADC_PU_BIT = 0;
   localparam int         DAC_PU_BIT = 1;
   localparam logic [7:0] MODE_RST   = 8'h00;
   localparam logic [7:0] RATE_RST   = 8'h00;
   localparam logic [7:0] POWER_RST  = 8'h00;
   // Sample period in link clocks at rate code 0, doubled per code step
   localparam logic [15:0] SAMP_BASE_CYCLES = 16'h0100;
   // ************************************************************
   // Host side timing and registers
   // ************************************************************
   localparam int         PCLK_MHZ         = 100;
   localparam int         SCLK_PERIOD_NS   = 80;
   localparam int         SCLK_HALF_CYCLES = SCLK_PERIOD_NS * PCLK_MHZ / 2000;
   localparam logic [3:0] SCLK_HALF_M1     = 4'(SCLK_HALF_CYCLES - 1);
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_TXDATA = 12'h008;
   localparam logic [11:0] OFS_RXDATA = 12'h00c;
   localparam logic        CTRL_RST   = 1'b0;
endpackage

// >>> core/dcsf_link_if.sv
interface dcsf_link_if;
   logic sclk;
   logic output_frame_sync;
   logic device_serial_out;
   logic host_frame_sync;
   logic serial_data_input;
   logic frame_sync_loopback;
   logic input_frame_sync;

   // Loop-back wiring ties the device's own output sync back to its input
   assign input_frame_sync = frame_sync_loopback ? output_frame_sync : host_frame_sync;

   modport dev (
      input  sclk,
      input  input_frame_sync,
      input  serial_data_input,
      output output_frame_sync,
      output device_serial_out
   );
   modport host (
      output sclk,
      output host_frame_sync,
      output serial_data_input,
      output frame_sync_loopback,
      input  output_frame_sync,
      input  device_serial_out
   );
endinterface

// >>> core/dcsf_codec_dev.sv
// The APB interface to the registers and the register addresses are this design's own decisions.
module dcsf_codec_dev (
   input  wire logic                              presetn,
   dcsf_link_if.dev                               link,
   input  wire logic [1:0][dcsf_pkg::WORD_W-1:0] adc_in,
   output      logic [1:0][dcsf_pkg::WORD_W-1:0] dac_word,
   output      logic [1:0]                        dac_strobe,
   output      logic [1:0]                        data_mode,
   output      logic [1:0]                        mixed_mode
);
   import dcsf_pkg::*;

   // ************************************************************
   // Reset release synchronised to the link clock
   // ************************************************************
   logic [1:0]  rst_sync_q;
   wire logic   rst_n = rst_sync_q[1];

   always_ff @(posedge link.sclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   // ************************************************************
   // Sample period timer shared by both units
   // ************************************************************
   logic [15:0]      samp_cnt_q;
   wire logic [1:0][1:0] u_rate;
   wire logic        samp_evt = (samp_cnt_q == 16'h0000);
   wire logic [15:0] samp_len = SAMP_BASE_CYCLES << u_rate[0];

   always_ff @(posedge link.sclk or negedge rst_n) begin
      if (!rst_n) begin
         samp_cnt_q <= 16'h0000;
      end else if (samp_evt) begin
         samp_cnt_q <= samp_len - 16'h0001;
      end else begin
         samp_cnt_q <= samp_cnt_q - 16'h0001;
      end
   end

   // ************************************************************
   // Cascade of two codec units
   // ************************************************************
   wire logic [1:0] u_fs_in;
   wire logic [1:0] u_din;
   wire logic [1:0] u_fs_out;
   wire logic [1:0] u_dout;

   // Unit 0 faces the host transmitter, unit 1 faces the host receiver
   assign u_fs_in[0]             = link.input_frame_sync;
   assign u_din[0]               = link.serial_data_input;
   assign u_fs_in[1]             = u_fs_out[0];
   assign u_din[1]               = u_dout[0];
   assign link.output_frame_sync = u_fs_out[1];
   assign link.device_serial_out = u_dout[1];

   for (genvar g = 0; g < 2; g++) begin : g_unit
      logic [15:0] rsr_q;
      logic [15:0] tsr_q;
      logic [15:0] dac_q;
      logic [4:0]  rcnt_q;
      logic [4:0]  tcnt_q;
      logic        rdone_q;
      logic        fs_q;
      logic        dout_q;
      logic        dstb_q;
      logic [7:0]  mode_q;
      logic [7:0]  mode_p_q;
      logic [7:0]  rate_q;
      logic [7:0]  rate_p_q;
      logic [7:0]  pwr_q;
      logic [2:0]  fcnt_q;

      wire logic        data_m   = mode_q[DATA_BIT];
      wire logic        mixed_m  = mode_q[MIXED_BIT];
      wire logic [2:0]  casc     = mode_q[CASC_LO+2:CASC_LO];
      wire logic [2:0]  addr     = rsr_q[ADDR_LO+2:ADDR_LO];
      wire logic [2:0]  reg_sel  = rsr_q[REG_LO+2:REG_LO];
      // Pure data mode takes every word as a sample; mixed mode looks at the flag
      wire logic        as_ctl   = rsr_q[CTL_BIT] & (~data_m | mixed_m);
      // Mixed mode still takes words without the control flag as samples
      wire logic        as_data  = (data_m | mixed_m) & ~as_ctl;
      wire logic        ctl_here = rdone_q & as_ctl & (addr == 3'h0);
      wire logic        ctl_fwd  = rdone_q & as_ctl & (addr != 3'h0);
      // Words for the far unit pass first, so host order decides placement
      wire logic        dat_here = rdone_q & as_data & (fcnt_q == casc);
      wire logic        dat_fwd  = rdone_q & as_data & (fcnt_q != casc);
      wire logic        pass_on  = rdone_q & ~as_ctl & ~as_data;
      wire logic        wr_here  = ctl_here & ~rsr_q[RD_BIT];
      wire logic [15:0] fwd_word = ctl_fwd ? {rsr_q[15:14], addr - 3'h1, rsr_q[10:0]} : rsr_q;
      wire logic        send_fwd = (ctl_fwd | dat_fwd | pass_on) & (tcnt_q == 5'h00);
      // In programming mode or with the ADC down the returned word is zero
      wire logic        adc_ok   = (data_m | mixed_m) & pwr_q[ADC_PU_BIT];
      wire logic [15:0] adc_word = adc_ok ? adc_in[g] : 16'h0000;
      // Sample event wins over a forward; a forward then is lost by design
      wire logic        tx_start = samp_evt | send_fwd;
      wire logic [15:0] tx_word  = samp_evt ? adc_word : fwd_word;

      // Receive: sync seen, then sixteen bits MSB first
      always_ff @(posedge link.sclk or negedge rst_n) begin
         if (!rst_n) begin
            rsr_q   <= 16'h0000;
            rcnt_q  <= 5'h00;
            rdone_q <= 1'b0;
         end else begin
            rdone_q <= (rcnt_q == 5'h01);
            if (u_fs_in[g] && (rcnt_q == 5'h00)) begin
               rcnt_q <= WORD_BITS;
            end else if (rcnt_q != 5'h00) begin
               rsr_q  <= {rsr_q[14:0], u_din[g]};
               rcnt_q <= rcnt_q - 5'h01;
            end
         end
      end

      // Transmit: sync cycle, then sixteen bits MSB first
      always_ff @(posedge link.sclk or negedge rst_n) begin
         if (!rst_n) begin
            tsr_q  <= 16'h0000;
            tcnt_q <= 5'h00;
            fs_q   <= 1'b0;
            dout_q <= 1'b0;
         end else if (tx_start) begin
            fs_q   <= 1'b1;
            tsr_q  <= tx_word;
            tcnt_q <= WORD_BITS;
         end else begin
            fs_q <= 1'b0;
            if (tcnt_q != 5'h00) begin
               dout_q <= tsr_q[15];
               tsr_q  <= {tsr_q[14:0], 1'b0};
               tcnt_q <= tcnt_q - 5'h01;
            end
         end
      end

      // Control registers; mode and rate wait in shadows for the sample event
      // so that both units switch on the same clock
      always_ff @(posedge link.sclk or negedge rst_n) begin
         if (!rst_n) begin
            mode_q   <= MODE_RST;
            mode_p_q <= MODE_RST;
            rate_q   <= RATE_RST;
            rate_p_q <= RATE_RST;
            pwr_q    <= POWER_RST;
         end else begin
            if (wr_here && (reg_sel == REG_MODE)) begin
               mode_p_q <= rsr_q[7:0];
            end
            if (wr_here && (reg_sel == REG_RATE)) begin
               rate_p_q <= rsr_q[7:0];
            end
            if (wr_here && (reg_sel == REG_POWER)) begin
               pwr_q <= rsr_q[7:0];
            end
            if (samp_evt) begin
               mode_q <= mode_p_q;
               rate_q <= rate_p_q;
            end
         end
      end

      // Sync counter restarts each period; a control word that took a sample
      // slot leaves the DAC holding its previous value
      always_ff @(posedge link.sclk or negedge rst_n) begin
         if (!rst_n) begin
            fcnt_q <= 3'h0;
            dac_q  <= 16'h0000;
            dstb_q <= 1'b0;
         end else begin
            dstb_q <= dat_here & pwr_q[DAC_PU_BIT];
            if (samp_evt) begin
               fcnt_q <= 3'h0;
            end else if (dat_here) begin
               fcnt_q <= 3'h0;
            end else if (dat_fwd) begin
               fcnt_q <= fcnt_q + 3'h1;
            end
            if (dat_here && pwr_q[DAC_PU_BIT]) begin
               dac_q <= rsr_q;
            end
         end
      end

      assign u_fs_out[g]   = fs_q;
      assign u_dout[g]     = dout_q;
      assign u_rate[g]     = rate_q[1:0];
      assign dac_word[g]   = dac_q;
      assign dac_strobe[g] = dstb_q;
      assign data_mode[g]  = mode_q[DATA_BIT];
      assign mixed_mode[g] = mode_q[MIXED_BIT];
   end
endmodule

// >>> core/dcsf_host_port.sv
module dcsf_host_port (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   dcsf_link_if.host        link
);
   import dcsf_pkg::*;

   // ************************************************************
   // Link clock divider; host drives on the fall, samples before the rise
   // ************************************************************
   logic [3:0]  div_q;
   logic        sclk_q;
   wire logic   tick = (div_q == SCLK_HALF_M1);
   wire logic   rise = tick & ~sclk_q;
   wire logic   fall = tick & sclk_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q  <= 4'h0;
         sclk_q <= 1'b0;
      end else if (tick) begin
         div_q  <= 4'h0;
         sclk_q <= ~sclk_q;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   // ************************************************************
   // Device outputs enter through two flip-flops
   // ************************************************************
   logic [1:0] fs_s_q;
   logic [1:0] d_s_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_s_q <= 2'h0;
         d_s_q  <= 2'h0;
      end else begin
         fs_s_q <= {fs_s_q[0], link.output_frame_sync};
         d_s_q  <= {d_s_q[0], link.device_serial_out};
      end
   end

   // ************************************************************
   // Registers and receive path
   // ************************************************************
   logic        loop_q;
   logic        pend_q;
   logic [15:0] txd_q;
   logic [15:0] rxd_q;
   logic        rxv_q;
   logic        ovr_q;
   logic [15:0] rsr_q;
   logic [4:0]  rcnt_q;
   logic [15:0] tsr_q;
   logic [4:0]  tcnt_q;
   logic        hfs_q;
   logic        hdat_q;

   wire logic sel_ctrl = (paddr == OFS_CTRL);
   wire logic sel_stat = (paddr == OFS_STATUS);
   wire logic sel_tx   = (paddr == OFS_TXDATA);
   wire logic sel_rx   = (paddr == OFS_RXDATA);
   wire logic mapped   = sel_ctrl | sel_stat | sel_tx | sel_rx;
   wire logic setup    = psel & ~penable;
   wire logic access   = psel & penable & pready;
   wire logic wr       = access & pwrite;
   wire logic rd_rx    = access & ~pwrite & sel_rx;
   wire logic busy     = (tcnt_q != 5'h00);
   // Loop-back: arm on each device sync that finds the transmitter idle, one word each time
   wire logic arm      = rise & loop_q & fs_s_q[1] & ~busy;
   wire logic start    = fall & ~loop_q & pend_q & ~busy;
   wire logic take     = pend_q & (arm | start);
   wire logic wr_tx    = wr & sel_tx & (~pend_q | take);
   wire logic rx_done  = rise & (rcnt_q == 5'h01);
   wire logic [31:0] rd_mux = sel_ctrl ? {31'h0000_0000, loop_q} :
                              sel_stat ? {28'h000_0000, busy, ovr_q, rxv_q, pend_q} :
                              sel_tx   ? {16'h0000, txd_q} :
                              sel_rx   ? {16'h0000, rxd_q} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_q <= CTRL_RST;
         txd_q  <= 16'h0000;
         pend_q <= 1'b0;
         rxv_q  <= 1'b0;
         ovr_q  <= 1'b0;
         rxd_q  <= 16'h0000;
      end else begin
         if (wr && sel_ctrl) begin
            loop_q <= pwdata[0];
         end
         if (wr_tx) begin
            txd_q <= pwdata[15:0];
         end
         // A new word or a new sample beats the clear in the same cycle
         pend_q <= wr_tx | (pend_q & ~take);
         rxv_q  <= rx_done | (rxv_q & ~rd_rx);
         ovr_q  <= (rx_done & rxv_q & ~rd_rx) | (ovr_q & ~rd_rx);
         if (rx_done) begin
            rxd_q <= {rsr_q[14:0], d_s_q[1]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsr_q  <= 16'h0000;
         rcnt_q <= 5'h00;
      end else if (rise) begin
         if (fs_s_q[1] && (rcnt_q == 5'h00)) begin
            rcnt_q <= WORD_BITS;
         end else if (rcnt_q != 5'h00) begin
            rsr_q  <= {rsr_q[14:0], d_s_q[1]};
            rcnt_q <= rcnt_q - 5'h01;
         end
      end
   end

   // ************************************************************
   // Transmit path; in loop-back an empty holding register sends a zero word
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsr_q  <= 16'h0000;
         tcnt_q <= 5'h00;
         hfs_q  <= 1'b0;
         hdat_q <= 1'b0;
      end else if (arm) begin
         tsr_q  <= pend_q ? txd_q : 16'h0000;
         tcnt_q <= WORD_BITS;
      end else if (fall) begin
         hfs_q <= start;
         if (start) begin
            tsr_q  <= txd_q;
            tcnt_q <= WORD_BITS;
         end else if (busy) begin
            hdat_q <= tsr_q[15];
            tsr_q  <= {tsr_q[14:0], 1'b0};
            tcnt_q <= tcnt_q - 5'h01;
         end
      end
   end

   assign link.sclk                = sclk_q;
   assign link.host_frame_sync     = hfs_q;
   assign link.serial_data_input   = hdat_q;
   assign link.frame_sync_loopback = loop_q;
endmodule

// >>> bench/dcsf_link_chk.sv
module dcsf_link_chk (
   input wire logic presetn,
   input wire logic sclk,
   input wire logic output_frame_sync,
   input wire logic host_frame_sync,
   input wire logic frame_sync_loopback,
   input wire logic input_frame_sync
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Helper counters
   // ************************************************************
   logic [4:0] gap_q;
   logic [3:0] age_q;
   logic       seen_q;

   // Gap saturates so a long quiet spell never wraps into a false short gap
   always_ff @(posedge sclk or negedge presetn) begin
      if (!presetn) begin
         gap_q <= 5'h1f;
      end else if (host_frame_sync) begin
         gap_q <= 5'h01;
      end else if (gap_q != 5'h1f) begin
         gap_q <= gap_q + 5'h01;
      end
   end

   always_ff @(posedge sclk or negedge presetn) begin
      if (!presetn) begin
         age_q  <= 4'h0;
         seen_q <= 1'b0;
      end else begin
         age_q  <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
         seen_q <= seen_q | output_frame_sync;
      end
   end

   // ************************************************************
   // Link properties
   // ************************************************************
   default clocking cb @(posedge sclk);
   endclocking
   default disable iff (!presetn);

   property p_ofs_width;
      output_frame_sync |=> !output_frame_sync;
   endproperty
   a_ofs_width: assert property (p_ofs_width)
      else $error("device sync longer than one clock");

   property p_ofs_period;
      $rose(output_frame_sync) |-> ##[1:600] $rose(output_frame_sync);
   endproperty
   a_ofs_period: assert property (p_ofs_period)
      else $error("device stopped sending words");

   property p_first_sync;
      (age_q == 4'hc) |-> seen_q;
   endproperty
   a_first_sync: assert property (p_first_sync)
      else $error("no sample event after reset");

   property p_hfs_width;
      host_frame_sync |=> !host_frame_sync;
   endproperty
   a_hfs_width: assert property (p_hfs_width)
      else $error("host sync longer than one clock");

   property p_hfs_gap;
      host_frame_sync |-> (gap_q >= 5'h11);
   endproperty
   a_hfs_gap: assert property (p_hfs_gap)
      else $error("host word shorter than sixteen bits");

   property p_hfs_loop;
      frame_sync_loopback |-> !host_frame_sync;
   endproperty
   a_hfs_loop: assert property (p_hfs_loop)
      else $error("host sync driven in loop-back");

   property p_loop_in;
      (frame_sync_loopback && output_frame_sync) |-> input_frame_sync;
   endproperty
   a_loop_in: assert property (p_loop_in)
      else $error("device sync not looped to input");

   property p_hfs_idle_start;
      (age_q < 4'h4) |-> !host_frame_sync;
   endproperty
   a_hfs_idle_start: assert property (p_hfs_idle_start)
      else $error("host word right after reset");
endmodule

// >>> bench/dual_codec_serial_frame_sequencing_bench.sv
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module dual_codec_serial_frame_sequencing_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import dcsf_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0][WORD_W-1:0] adc_in, dac_word;
   logic [1:0] dac_strobe, data_mode, mixed_mode;
   logic e;
   int failures, checks_done, split_cnt, n;

   dcsf_link_if dcsf_link_if_i ();
   dcsf_host_port dcsf_host_port_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(dcsf_link_if_i));
   dcsf_codec_dev dcsf_codec_dev_i (.presetn(presetn), .link(dcsf_link_if_i), .adc_in(adc_in),
      .dac_word(dac_word), .dac_strobe(dac_strobe), .data_mode(data_mode),
      .mixed_mode(mixed_mode));
   dcsf_link_chk dcsf_link_chk_i (.presetn(presetn), .sclk(dcsf_link_if_i.sclk),
      .output_frame_sync(dcsf_link_if_i.output_frame_sync),
      .host_frame_sync(dcsf_link_if_i.host_frame_sync),
      .frame_sync_loopback(dcsf_link_if_i.frame_sync_loopback),
      .input_frame_sync(dcsf_link_if_i.input_frame_sync));

   always #5 pclk = ~pclk;
   // Both units must switch modes on the same clock
   always @(posedge dcsf_link_if_i.sclk) begin
      if (presetn && (data_mode[0] !== data_mode[1] || mixed_mode[0] !== mixed_mode[1])) begin
         split_cnt++;
      end
   end
   // ************************************************************
   // Bus and link tasks
   // ************************************************************
   // Request held until the rising edge that samples pready high; data taken there
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      if (k >= 50) failures++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tx(input logic [15:0] w);
      int k;
      k = 0;
      apb(1'b1, OFS_TXDATA, {16'h0000, w});
      do begin apb(1'b0, OFS_STATUS, 32'h0000_0000); k++; end while (q[0] !== 1'b0 && k < 2000);
   endtask
   // Mid-period start keeps both words of a pair inside one sample period
   task automatic pair(input logic [15:0] w1, input logic [15:0] w0);
      @(posedge dcsf_link_if_i.output_frame_sync);
      repeat (400) @(posedge pclk);
      tx(w1);
      tx(w0);
   endtask
   task automatic init(input logic lb, input logic [7:0] mode);
      apb(1'b1, OFS_CTRL, {31'h0000_0000, lb});
      pair(16'h8a03, 16'h8203);
      pair(16'h8900, 16'h8100);
      pair(16'h8800 | mode, 16'h8000 | mode);
   endtask
   task automatic wait_sig(input int b);
      n = 0;
      while (((b == 0) ? dac_strobe[0] : (b == 1) ? dac_strobe[1] : (b == 2) ? &data_mode
             : &mixed_mode) !== 1'b1 && n < 5000) begin
         @(negedge pclk);
         n++;
      end
      @(posedge pclk);
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      adc_in = {16'h0123, 16'h0456};
      do_reset();
      apb(1'b0, OFS_CTRL, 32'h0000_0000);
      `CHK("ctrl", {31'h0000_0000, CTRL_RST}, q)
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      `CHK("status", 32'h0000_0000, q)
      `CHK("modes", 4'h0, {data_mode, mixed_mode})
      apb(1'b1, 12'h010, 32'h0000_5a5a);
      `CHK("unmapped err", 1'b1, e)
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK("unmapped data", 32'h0000_0000, q)
      $display("test reset done");
      init(1'b1, 8'h05);
      wait_sig(2);
      `CHK("data mode", 4'hc, {data_mode, mixed_mode})
      for (int i = 0; i < 2; i++) begin
         pair(i ? 16'h0000 : 16'h7fff, i ? 16'h4321 : 16'h0001);
         wait_sig(0);
         repeat (200) @(posedge pclk);
         `CHK("dac pair", i ? 32'h0000_4321 : 32'h7fff_0001, dac_word)
      end
      $display("test loop-back data done");
      do_reset();
      init(1'b0, 8'h06);
      wait_sig(3);
      `CHK("mixed mode", 4'h3, {data_mode, mixed_mode})
      @(posedge dcsf_link_if_i.output_frame_sync);
      repeat (400) @(posedge pclk);
      tx(16'h8a03);
      tx(16'h8201);
      tx(16'h2468);
      tx(16'h1357);
      wait_sig(1);
      repeat (200) @(posedge pclk);
      `CHK("dac unit1", 16'h2468, dac_word[1])
      `CHK("dac unit0 off", 16'h0000, dac_word[0])
      `CHK("split", 0, split_cnt)
      $display("test mixed done");
      summarize();
   end
   initial begin
      repeat (90000) @(posedge pclk);
      failures++;
      summarize();
   end
endmodule
